// ===== pes_pin_mux.sv
// per-pin output mux and driver enable for the upper port e pins
`timescale 1ns/1ns
`default_nettype none
module pes_pin_mux (
   input wire logic [1:0] sel_i,
   input wire logic dir_i,
   input wire logic port_data_i,
   input wire logic pwm_i,
   input wire logic trig_i,
   input wire logic trig_allowed_i,
   output logic out_o,
   output logic oe_o
);
   import pes_pkg::*;

   // peripheral selection overrides direction bit
   always_comb begin
      out_o = 1'b0;
      oe_o = 1'b0;
      case (sel_i)
         SEL_PORT: begin
            out_o = port_data_i;
            oe_o = dir_i;
         end
         SEL_PWM: begin
            out_o = pwm_i;
            oe_o = 1'b1;
         end
         SEL_TRIGGER: begin
            // prohibited code elsewhere leaves pin released
            out_o = trig_allowed_i & trig_i;
            oe_o = trig_allowed_i;
         end
         default: begin
            out_o = 1'b0;
            oe_o = 1'b0;
         end
      endcase
   end
endmodule : pes_pin_mux
`default_nettype wire

// ===== pes_pkg.sv
// shared constants for the port e upper pin function select block
package pes_pkg;
   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned FIELD_W = 2;
   localparam int unsigned REG_W = 16;
   localparam int unsigned ADDR_W = 4;
   // register byte offsets
   localparam logic [ADDR_W-1:0] OFS_SELECT = 4'h0;
   localparam logic [ADDR_W-1:0] OFS_DIRECTION = 4'h4;
   localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 4'h8;
   // writable bit masks, reserved bits stay zero
   localparam logic [REG_W-1:0] SELECT_MASK = 16'h0FFF;
   localparam logic [REG_W-1:0] DIRECTION_MASK = 16'h003F;
   // reset values
   localparam logic [REG_W-1:0] SELECT_RESET = 16'h0000;
   localparam logic [REG_W-1:0] DIRECTION_RESET = 16'h0000;
   // field codes
   localparam logic [1:0] SEL_PORT = 2'h0;
   localparam logic [1:0] SEL_PWM = 2'h1;
   localparam logic [1:0] SEL_TRIGGER = 2'h2;
   // axi responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : pes_pkg

// ===== pes_select.sv
// port e upper pin function select register with axi4-lite access
// Operation
// - 16-bit read/write select fields route pins
// - bits 15:12 read zero, write zero
// - bits 11:10 pin 21: port or w-neg
// - bits 9:8 pin 20: port or v-neg
// - bits 7:6 pin 19: port or u-neg
// - bits 5:4 pin 18: port or w-pos
// - bits 3:2 pin 17: port or v-pos
// - bits 1:0 pin 16: port/u-pos/trigger
// - all fields reset to port mode
// - direction acts only in port mode
// - direction one output, zero input
`timescale 1ns/1ns
`default_nettype none
module pes_select (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic [pes_pkg::ADDR_W-1:0] AWADDR_I,
   input wire logic AWVALID_I,
   output logic AWREADY_O,
   input wire logic [31:0] WDATA_I,
   input wire logic [3:0] WSTRB_I,
   input wire logic WVALID_I,
   output logic WREADY_O,
   output logic [1:0] BRESP_O,
   output logic BVALID_O,
   input wire logic BREADY_I,
   input wire logic [pes_pkg::ADDR_W-1:0] ARADDR_I,
   input wire logic ARVALID_I,
   output logic ARREADY_O,
   output logic [31:0] RDATA_O,
   output logic [1:0] RRESP_O,
   output logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic [pes_pkg::PIN_COUNT-1:0] PORT_DATA_I,
   input wire logic [pes_pkg::PIN_COUNT-1:0] PIN_IN_I,
   input wire logic U_PHASE_POS_PWM_I,
   input wire logic V_PHASE_POS_PWM_I,
   input wire logic W_PHASE_POS_PWM_I,
   input wire logic U_PHASE_NEG_PWM_I,
   input wire logic V_PHASE_NEG_PWM_I,
   input wire logic W_PHASE_NEG_PWM_I,
   input wire logic BREAK_TRIGGER_OUT_I,
   output logic [pes_pkg::PIN_COUNT-1:0] PIN_OUT_O,
   output logic [pes_pkg::PIN_COUNT-1:0] PIN_OE_O
);
   import pes_pkg::*;

   // registers behind the bus; prohibited codes are stored as written
   logic [REG_W-1:0] select_q;
   logic [REG_W-1:0] direction_q;
   logic aw_held_q;
   logic w_held_q;
   logic [ADDR_W-1:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   // pin side: sync stages and timer routing
   logic [PIN_COUNT-1:0] pin_meta_q;
   logic [PIN_COUNT-1:0] pin_sync_q;
   logic [PIN_COUNT-1:0] pwm_vec;
   logic do_write;

   // merge byte lanes of the low half, keeping reserved bits clear
   // lanes 2 and 3 hold no register bits, so they are dropped
   function automatic logic [REG_W-1:0] merge_lanes(
      input logic [REG_W-1:0] old_v,
      input logic [31:0] new_v,
      input logic [3:0] strb,
      input logic [REG_W-1:0] mask
   );
      logic [REG_W-1:0] res;
      res = old_v;
      if (strb[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (strb[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res & mask;
   endfunction : merge_lanes

   // address, data held until both are in, one write at a time
   // holding each channel lets the master offer them in either order
   assign AWREADY_O = ~aw_held_q & ~bvalid_q;
   assign WREADY_O = ~w_held_q & ~bvalid_q;
   assign do_write = aw_held_q & w_held_q & ~bvalid_q;

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         aw_held_q <= 1'b0;
         awaddr_q <= 4'h0;
      end else if (AWVALID_I && AWREADY_O) begin
         aw_held_q <= 1'b1;
         awaddr_q <= AWADDR_I;
      end else if (do_write) begin
         aw_held_q <= 1'b0;
      end
   end

   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         w_held_q <= 1'b0;
         wdata_q <= 32'h0000_0000;
         wstrb_q <= 4'h0;
      end else if (WVALID_I && WREADY_O) begin
         w_held_q <= 1'b1;
         wdata_q <= WDATA_I;
         wstrb_q <= WSTRB_I;
      end else if (do_write) begin
         w_held_q <= 1'b0;
      end
   end

   // every field 00 leaves all six pins as port pins
   // reset to port mode
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         select_q <= SELECT_RESET;
      end else if (do_write && awaddr_q == OFS_SELECT) begin
         select_q <= merge_lanes(select_q, wdata_q, wstrb_q, SELECT_MASK);
      end
   end

   // direction bits for pins 16 to 21
   // upper ten bits are reserved and always read zero
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         direction_q <= DIRECTION_RESET;
      end else if (do_write && awaddr_q == OFS_DIRECTION) begin
         direction_q <= merge_lanes(direction_q, wdata_q, wstrb_q,
            DIRECTION_MASK);
      end
   end

   // write response; unmapped or read-only offsets answer slverr
   // a refused write leaves every register as it was
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (do_write) begin
         bvalid_q <= 1'b1;
         bresp_q <= (awaddr_q == OFS_SELECT || awaddr_q == OFS_DIRECTION)
            ? RESP_OKAY : RESP_SLVERR;
      end else if (BREADY_I) begin
         bvalid_q <= 1'b0;
      end
   end
   assign BVALID_O = bvalid_q;
   assign BRESP_O = bresp_q;

   // read channel, one read outstanding
   // answer one edge after the address is taken, held until rready
   assign ARREADY_O = ~rvalid_q;
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= 32'h0000_0000;
      end else if (ARVALID_I && ARREADY_O) begin
         rvalid_q <= 1'b1;
         rresp_q <= RESP_OKAY;
         case (ARADDR_I)
            OFS_SELECT: rdata_q <= {16'h0000, select_q & SELECT_MASK};
            OFS_DIRECTION: rdata_q <= {16'h0000, direction_q};
            OFS_PIN_STATE: rdata_q <= {26'h0000000, pin_sync_q};
            default: begin
               rdata_q <= 32'h0000_0000;
               rresp_q <= RESP_SLVERR;
            end
         endcase
      end else if (RREADY_I) begin
         rvalid_q <= 1'b0;
      end
   end
   assign RVALID_O = rvalid_q;
   assign RDATA_O = rdata_q;
   assign RRESP_O = rresp_q;

   // pin levels come from outside; two stages before software sees them
   // only the second stage is read, the first may still be settling
   always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
      if (RST_I) begin
         pin_meta_q <= 6'h00;
         pin_sync_q <= 6'h00;
      end else begin
         pin_meta_q <= PIN_IN_I;
         pin_sync_q <= pin_meta_q;
      end
   end

   // timer outputs share this clock, so no sync stage is spent on them
   // pwm source per pin, 16 first
   assign pwm_vec = {W_PHASE_NEG_PWM_I, V_PHASE_NEG_PWM_I,
      U_PHASE_NEG_PWM_I, W_PHASE_POS_PWM_I, V_PHASE_POS_PWM_I,
      U_PHASE_POS_PWM_I};

   // only pin 16 has a trigger route; the mux releases the others
   // codes 10 and 11 on pins 17-21 release the pin
   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_pin
      pes_pin_mux u_mux (
         .sel_i(select_q[FIELD_W*p +: FIELD_W]),
         .dir_i(direction_q[p]),
         .port_data_i(PORT_DATA_I[p]),
         .pwm_i(pwm_vec[p]),
         .trig_i(BREAK_TRIGGER_OUT_I),
         .trig_allowed_i(p == 0),
         .out_o(PIN_OUT_O[p]),
         .oe_o(PIN_OE_O[p])
      );
   end
endmodule : pes_select
`default_nettype wire

// ===== pes_select_chk.sv
// port checks for the pin select block
`timescale 1ns/1ns
`default_nettype none
module pes_select_chk (
   input wire logic CORE_CLK_I,
   input wire logic RST_I,
   input wire logic AWREADY_O,
   input wire logic BVALID_O,
   input wire logic [1:0] BRESP_O,
   input wire logic BREADY_I,
   input wire logic ARVALID_I,
   input wire logic ARREADY_O,
   input wire logic [31:0] RDATA_O,
   input wire logic RVALID_O,
   input wire logic RREADY_I,
   input wire logic [pes_pkg::PIN_COUNT-1:0] PIN_OE_O
);
   import pes_pkg::*;
   default clocking @(posedge CORE_CLK_I); endclocking
   default disable iff (RST_I);
   // read taken, then answer held until taken
   sequence s_ar_taken;
      ARVALID_I && ARREADY_O;
   endsequence
   sequence s_r_wait;
      RVALID_O && !RREADY_I;
   endsequence
   sequence s_r_hold;
      RVALID_O && $stable(RDATA_O);
   endsequence
   // bits 31:12 of every read word stay clear
   sequence s_rsv_clear;
      RDATA_O[31:12] == 20'h00000;
   endsequence
   // write answer carries only okay or slave error
   sequence s_b_legal;
      BRESP_O == RESP_OKAY || BRESP_O == RESP_SLVERR;
   endsequence
   a_rd_answer: assert property (s_ar_taken |=> RVALID_O)
      else $error("read answer late");
   a_rd_hold: assert property (s_r_wait |=> s_r_hold)
      else $error("read data dropped");
   a_rd_done: assert property (RVALID_O && RREADY_I |=> !RVALID_O)
      else $error("read answer stuck");
   a_b_hold: assert property (BVALID_O && !BREADY_I |=> BVALID_O)
      else $error("write answer dropped");
   a_b_done: assert property (BVALID_O && BREADY_I |=> !BVALID_O)
      else $error("write answer stuck");
   a_b_code: assert property (BVALID_O |-> s_b_legal)
      else $error("write answer code wrong");
   a_aw_block: assert property (BVALID_O |-> !AWREADY_O)
      else $error("address taken too early");
   a_ar_block: assert property (ARREADY_O == !RVALID_O)
      else $error("read ready wrong");
   a_rsv_zero: assert property (RVALID_O |-> s_rsv_clear)
      else $error("reserved bits set");
   // pins released right after reset
   a_reset_port: assert property ($fell(RST_I) |-> PIN_OE_O == '0)
      else $error("pin driven after reset");
endmodule : pes_select_chk
bind pes_select pes_select_chk u_chk (.CORE_CLK_I, .RST_I, .AWREADY_O,
   .BVALID_O, .BRESP_O, .BREADY_I, .ARVALID_I, .ARREADY_O, .RDATA_O,
   .RVALID_O, .RREADY_I, .PIN_OE_O);
`default_nettype wire

// ===== pes_select_tb_top.sv
// self-checking bench for the pin select block
`timescale 1ns/1ns
`default_nettype none
module pes_select_tb_top;
   import pes_pkg::*;
   logic CORE_CLK_I = 0, RST_I = 1, AWVALID_I = 0, WVALID_I = 0, trig = 0;
   logic BREADY_I = 0, ARVALID_I = 0, RREADY_I = 0;
   logic [3:0] AWADDR_I = 0, ARADDR_I = 0, WSTRB_I = 0;
   logic [31:0] WDATA_I = 0;
   logic [5:0] PORT_DATA_I = 0, PIN_IN_I = 0, pwm = 0;
   wire AWREADY_O, WREADY_O, BVALID_O, ARREADY_O, RVALID_O;
   wire [1:0] BRESP_O, RRESP_O;
   wire [31:0] RDATA_O;
   wire [5:0] PIN_OUT_O, PIN_OE_O;
   int n_fail = 0, n_checks = 0;
   pes_select DUT (.CORE_CLK_I, .RST_I, .AWADDR_I, .AWVALID_I, .AWREADY_O,
      .WDATA_I, .WSTRB_I, .WVALID_I, .WREADY_O, .BRESP_O, .BVALID_O,
      .BREADY_I, .ARADDR_I, .ARVALID_I, .ARREADY_O, .RDATA_O, .RRESP_O,
      .RVALID_O, .RREADY_I, .PORT_DATA_I, .PIN_IN_I,
      .U_PHASE_POS_PWM_I(pwm[0]), .V_PHASE_POS_PWM_I(pwm[1]),
      .W_PHASE_POS_PWM_I(pwm[2]), .U_PHASE_NEG_PWM_I(pwm[3]),
      .V_PHASE_NEG_PWM_I(pwm[4]), .W_PHASE_NEG_PWM_I(pwm[5]),
      .BREAK_TRIGGER_OUT_I(trig), .PIN_OUT_O, .PIN_OE_O);
   always #10 CORE_CLK_I = ~CORE_CLK_I;
   task automatic chk(input string n, input logic [31:0] s, e);
      n_checks++;
      if (s !== e) begin
         n_fail++;
         $display("MISMATCH %s exp %h seen %h", n, e, s);
      end
   endtask : chk
   // write: both channels offered, each dropped once taken
   task automatic wr(input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s, input logic [1:0] r);
      logic aw, w;
      aw = 0;
      w = 0;
      @(posedge CORE_CLK_I);
      {AWADDR_I, WDATA_I, WSTRB_I} <= {a, d, s};
      {AWVALID_I, WVALID_I, BREADY_I} <= 3'h7;
      do begin
         @(posedge CORE_CLK_I);
         if (!aw && AWREADY_O === 1'b1) begin
            aw = 1;
            AWVALID_I <= 0;
         end
         if (!w && WREADY_O === 1'b1) begin
            w = 1;
            WVALID_I <= 0;
         end
      end while (BVALID_O !== 1'b1);
      BREADY_I <= 0;
      chk("bresp", BRESP_O, r);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
      input logic [1:0] r);
      @(posedge CORE_CLK_I);
      {ARADDR_I, ARVALID_I, RREADY_I} <= {a, 2'h3};
      do @(posedge CORE_CLK_I); while (ARREADY_O !== 1'b1);
      ARVALID_I <= 0;
      do @(posedge CORE_CLK_I); while (RVALID_O !== 1'b1);
      RREADY_I <= 0;
      chk("rdata", RDATA_O, e);
      chk("rresp", RRESP_O, r);
   endtask : rd
   // port mode follows direction and port data
   task automatic t_port;
      PORT_DATA_I <= 6'h2A;
      rd(OFS_SELECT, 0, RESP_OKAY);
      wr(OFS_DIRECTION, 32'h3F, 4'hF, RESP_OKAY);
      #1 chk("oe", PIN_OE_O, 6'h3F);
      chk("out", PIN_OUT_O, 6'h2A);
      wr(OFS_DIRECTION, 32'h05, 4'hF, RESP_OKAY);
      #1 chk("oe", PIN_OE_O, 6'h05);
   endtask : t_port
   // pwm selection overrides direction, one phase at a time
   task automatic t_pwm;
      // only port or pwm codes written
      wr(OFS_SELECT, 32'h0555, 4'hF, RESP_OKAY);
      for (int i = 0; i < PIN_COUNT; i++) begin
         pwm <= 6'h01 << i;
         @(posedge CORE_CLK_I);
         chk("out", PIN_OUT_O, 6'h01 << i);
         chk("oe", PIN_OE_O, 6'h3F);
      end
      rd(OFS_SELECT, 32'h0555, RESP_OKAY);
      // upper byte lane alone clears pins 20 and 21
      wr(OFS_SELECT, 0, 4'h2, RESP_OKAY);
      rd(OFS_SELECT, 32'h0055, RESP_OKAY);
   endtask : t_pwm
   // trigger on the lowest pin, others back to port
   task automatic t_trig;
      trig <= 1;
      wr(OFS_SELECT, 32'h0002, 4'hF, RESP_OKAY);
      #1 chk("oe", PIN_OE_O, 6'h05);
      chk("out", PIN_OUT_O & 6'h05, 6'h01);
      @(posedge CORE_CLK_I);
      trig <= 0;
      @(posedge CORE_CLK_I);
      chk("out", PIN_OUT_O & 6'h05, 6'h00);
   endtask : t_trig
   // read-only and unmapped places refuse
   task automatic t_map;
      PIN_IN_I <= 6'h15;
      wr(OFS_PIN_STATE, 32'h3F, 4'hF, RESP_SLVERR);
      rd(OFS_PIN_STATE, 32'h15, RESP_OKAY);
      rd(4'hC, 0, RESP_SLVERR);
      wr(4'hC, 32'h1, 4'hF, RESP_SLVERR);
      rd(OFS_DIRECTION, 32'h05, RESP_OKAY);
      rd(OFS_SELECT, 32'h0002, RESP_OKAY);
   endtask : t_map
   // reset in mid-run returns every pin to port mode
   task automatic t_reset;
      RST_I <= 1;
      repeat (2) @(posedge CORE_CLK_I);
      RST_I <= 0;
      chk("oe", PIN_OE_O, 6'h00);
      rd(OFS_SELECT, 0, RESP_OKAY);
      rd(OFS_DIRECTION, 0, RESP_OKAY);
   endtask : t_reset
   task automatic close_out;
      $display("checks %0d mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : close_out
   initial begin
      repeat (6) @(posedge CORE_CLK_I);
      RST_I <= 0;
      chk("oe", PIN_OE_O, 6'h00);
      t_port;
      t_pwm;
      t_trig;
      t_map;
      t_reset;
      close_out;
   end
   // watchdog far beyond the fewer than a hundred cycles needed
   initial begin
      #100000;
      n_fail++;
      close_out;
   end
endmodule : pes_select_tb_top
`default_nettype wire
